// ### core/phyec_pkg.sv
package phyec_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_RX_ERR_CNT = 5'h13;
    localparam logic [4:0] ADDR_FALSE_CARRIER_CNT = 5'h14;
    localparam logic [4:0] ADDR_DISCONNECT_CNT = 5'h15;
    localparam logic [4:0] ADDR_TEN_BASE_T_CTRL = 5'h16;

    // control/status field positions
    localparam int BIT_LINK_INTEG_DIS = 15;
    localparam int BIT_JABBER_DIS = 14;
    localparam int BIT_ECHO_DIS = 13;
    localparam int BIT_HEARTBEAT_DIS = 12;
    localparam int POS_SQUELCH = 10;
    localparam int BIT_EOF_ERR = 8;
    localparam int BIT_DISC_STATE = 7;
    localparam int BIT_LINK_STATUS = 6;
    localparam int POS_TRIM = 3;

    // reset values
    localparam logic [15:0] RESET_REG_VALUE = 16'h0000;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_ONE = 8'h01;

    // speed selection codes
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;

    // squelch selection codes: 300 mV, 197 mV, 450 mV
    localparam logic [1:0] SQUELCH_300MV = 2'h0;
    localparam logic [1:0] SQUELCH_197MV = 2'h1;
    localparam logic [1:0] SQUELCH_450MV = 2'h2;

    // trim adjustment in percent
    localparam logic signed [3:0] TRIM_P6 = 4'sh6;
    localparam logic signed [3:0] TRIM_P4 = 4'sh4;
    localparam logic signed [3:0] TRIM_P2 = 4'sh2;
    localparam logic signed [3:0] TRIM_ZERO = 4'sh0;
    localparam logic signed [3:0] TRIM_M2 = -4'sh2;
    localparam logic signed [3:0] TRIM_M4 = -4'sh4;

    // jabber limit
    localparam int CLK_FREQ_KHZ = 10000;
    localparam int JABBER_LIMIT_MS = 20;
    localparam int JABBER_CYC_INT = JABBER_LIMIT_MS * CLK_FREQ_KHZ;
    localparam int JAB_W = 18;
    localparam logic [JAB_W-1:0] JABBER_CYCLES = JAB_W'(JABBER_CYC_INT);
    localparam logic [JAB_W-1:0] JAB_RESET = 18'h0_0000;

    // counter state
    typedef struct packed {
        logic [7:0] count;
    } phyec_cnt_s;

endpackage

// ### core/phyec_cnt_if.sv
`timescale 1ns/1ps
interface phyec_cnt_if;
    logic inc;
    logic clr;
    logic [7:0] count;

    // counter side and register side
    modport ctr (input inc, input clr, output count);
    modport user (output inc, output clr, input count);
endinterface

// ### core/phyec_sat_counter.sv
`timescale 1ns/1ps
module phyec_sat_counter
    import phyec_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic softReset,
    // counter link
    phyec_cnt_if.ctr cnt
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    phyec_cnt_s state_r;
    phyec_cnt_s state_nxt;

    // next count
    always_comb begin
        state_nxt = state_r;
        if (!resetn || softReset) begin
            state_nxt.count = CNT_RESET;
        end else if (cnt.clr) begin
            state_nxt.count = cnt.inc ? CNT_ONE : CNT_RESET;
        end else if (cnt.inc && state_r.count != CNT_MAX) begin
            state_nxt.count = state_r.count + CNT_ONE;
        end
    end

    always_ff @(posedge clk) begin
        state_r <= state_nxt;
    end

    assign cnt.count = state_r.count;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn || softReset);

    property p_saturate;
        cnt.count == CNT_MAX && !cnt.clr |=> cnt.count == CNT_MAX;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("counter left maximum without a read");

    property p_count_up;
        cnt.inc && !cnt.clr && cnt.count != CNT_MAX
            |=> cnt.count == $past(cnt.count) + CNT_ONE;
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("counter missed an event");

    property p_clear_keep;
        cnt.clr |=> cnt.count == ($past(cnt.inc) ? CNT_ONE : CNT_RESET);
    endproperty
    a_clear_keep: assert property (p_clear_keep)
        else $error("read clear lost or kept wrong value");

    property p_no_spurious;
        !cnt.inc && !cnt.clr |=> $stable(cnt.count);
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("counter changed without event or read");

endmodule

// ### core/phyec_top.sv
`timescale 1ns/1ps
module phyec_top
    import phyec_pkg::*;
#(
    parameter logic [JAB_W-1:0] JABBER_LIMIT_CYC = JABBER_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic softReset,
    // management register port
    input wire logic [4:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    // operating mode
    input wire logic [1:0] speedSel,
    input wire logic halfDuplex,
    // receive and monitor events
    input wire logic rxErrPktEnd,
    input wire logic rxCollision,
    input wire logic falseCarrierEvt,
    input wire logic cimUnstableEnter,
    input wire logic cimLinkBroken,
    input wire logic eofErrEvt,
    input wire logic linkIntegrityOk,
    // transmit side
    input wire logic txEnPin,
    input wire logic heartbeatReq,
    // controls out to line logic
    output logic linkPass10,
    output logic crsOut,
    output logic heartbeatOut,
    output logic txShutoff,
    output logic [1:0] squelchSel,
    output logic [1:0] actSquelchSel,
    output logic signed [3:0] txTrimPct
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic linkIntegDis;
        logic jabberDis;
        logic echoDis;
        logic heartbeatDis;
        logic [1:0] squelch;
        logic [2:0] trim;
        logic eofErr;
        logic discFlag;
        logic linkPass;
        logic crs;
        logic heartbeat;
        logic txEnMeta;
        logic txEnSync;
        logic [JAB_W-1:0] jabCnt;
        logic jabbed;
        logic [15:0] rdData;
    } phyec_top_s;

    phyec_top_s state_r;
    phyec_top_s state_nxt;

    phyec_cnt_if rxErrIf ();
    phyec_cnt_if falseCarrierIf ();
    phyec_cnt_if discIf ();

    logic speed10;
    logic speed1000;
    logic rdCtrl;
    logic wrCtrl;
    logic [15:0] ctrlView;

    assign speed10 = (speedSel == SPEED_10);
    assign speed1000 = (speedSel == SPEED_1000);
    assign rdCtrl = regRdEn && regAddr == ADDR_TEN_BASE_T_CTRL;
    assign wrCtrl = regWrEn && regAddr == ADDR_TEN_BASE_T_CTRL;

    // ----------------------------------------------------------------
    // event counters
    // ----------------------------------------------------------------
    // error packet count, only at 100/1000
    assign rxErrIf.inc = rxErrPktEnd && !rxCollision && !speed10;
    // false carrier count, only at 100/1000
    assign falseCarrierIf.inc = falseCarrierEvt && !speed10;
    assign discIf.inc = cimUnstableEnter;

    // reads clear, writes have no path here
    assign rxErrIf.clr = regRdEn && regAddr == ADDR_RX_ERR_CNT;
    assign falseCarrierIf.clr = regRdEn && regAddr == ADDR_FALSE_CARRIER_CNT;
    assign discIf.clr = regRdEn && regAddr == ADDR_DISCONNECT_CNT;

    phyec_sat_counter uRxErrCnt (
        .clk(clk),
        .resetn(resetn),
        .softReset(softReset),
        .cnt(rxErrIf.ctr)
    );

    phyec_sat_counter uFalseCarrierCnt (
        .clk(clk),
        .resetn(resetn),
        .softReset(softReset),
        .cnt(falseCarrierIf.ctr)
    );

    phyec_sat_counter uDiscCnt (
        .clk(clk),
        .resetn(resetn),
        .softReset(softReset),
        .cnt(discIf.ctr)
    );

    // ----------------------------------------------------------------
    // control register view
    // ----------------------------------------------------------------
    // reserved bits 9 and 2:0 read zero
    always_comb begin
        ctrlView = RESET_REG_VALUE;
        ctrlView[BIT_LINK_INTEG_DIS] = state_r.linkIntegDis;
        ctrlView[BIT_JABBER_DIS] = state_r.jabberDis;
        ctrlView[BIT_ECHO_DIS] = state_r.echoDis;
        ctrlView[BIT_HEARTBEAT_DIS] = state_r.heartbeatDis;
        ctrlView[POS_SQUELCH +: 2] = state_r.squelch;
        ctrlView[BIT_EOF_ERR] = state_r.eofErr;
        ctrlView[BIT_DISC_STATE] = state_r.discFlag;
        ctrlView[BIT_LINK_STATUS] = state_r.linkPass;
        ctrlView[POS_TRIM +: 3] = state_r.trim;
    end

    // trim code to percent
    function automatic logic signed [3:0] trimPct(input logic [2:0] code);
        case (code)
            3'h3, 3'h2: trimPct = TRIM_P6;
            3'h1: trimPct = TRIM_P4;
            3'h0: trimPct = TRIM_P2;
            3'h7: trimPct = TRIM_ZERO;
            3'h6: trimPct = TRIM_M2;
            default: trimPct = TRIM_M4;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        // pin synchroniser, first stage read only by second
        state_nxt.txEnMeta = txEnPin;
        state_nxt.txEnSync = state_r.txEnMeta;

        // writable controls; read-only bits take no write
        if (wrCtrl) begin
            state_nxt.linkIntegDis = regWrData[BIT_LINK_INTEG_DIS];
            state_nxt.jabberDis = regWrData[BIT_JABBER_DIS];
            state_nxt.echoDis = regWrData[BIT_ECHO_DIS];
            state_nxt.heartbeatDis = regWrData[BIT_HEARTBEAT_DIS];
            state_nxt.squelch = regWrData[POS_SQUELCH +: 2];
            state_nxt.trim = regWrData[POS_TRIM +: 3];
        end

        // sticky end-of-frame error, set beats read clear
        state_nxt.eofErr = (state_r.eofErr && !rdCtrl)
            || (eofErrEvt && speed10);
        // sticky disconnect, set beats read clear
        state_nxt.discFlag = (state_r.discFlag && !rdCtrl)
            || (cimLinkBroken && speed10);

        // bypass forces pass, 10 Mb/s only
        state_nxt.linkPass = speed10
            && (state_r.linkIntegDis || linkIntegrityOk);

        state_nxt.crs = state_r.txEnSync
            && !(state_r.echoDis && !speed1000);

        // heartbeat suppressed only in 10 Mb/s half duplex
        state_nxt.heartbeat = heartbeatReq
            && !(state_r.heartbeatDis && speed10 && halfDuplex);

        // jabber timer; disabled means unlimited length
        if (!speed10 || !state_r.txEnSync) begin
            state_nxt.jabCnt = JAB_RESET;
            state_nxt.jabbed = 1'b0;
        end else if (state_r.jabberDis) begin
            state_nxt.jabCnt = JAB_RESET;
            state_nxt.jabbed = 1'b0;
        end else if (state_r.jabCnt == JABBER_LIMIT_CYC) begin
            state_nxt.jabbed = 1'b1;
        end else begin
            state_nxt.jabCnt = state_r.jabCnt + 18'h0_0001;
        end

        // registered read data; unknown addresses read zero
        if (regRdEn) begin
            case (regAddr)
                ADDR_RX_ERR_CNT:
                    state_nxt.rdData = {8'h00, rxErrIf.count};
                ADDR_FALSE_CARRIER_CNT:
                    state_nxt.rdData = {8'h00, falseCarrierIf.count};
                ADDR_DISCONNECT_CNT:
                    state_nxt.rdData = {8'h00, discIf.count};
                ADDR_TEN_BASE_T_CTRL:
                    state_nxt.rdData = ctrlView;
                default:
                    state_nxt.rdData = RESET_REG_VALUE;
            endcase
        end

        // soft reset clears both sticky flags, keeps controls and link status
        if (softReset) begin
            state_nxt.eofErr = 1'b0;
            state_nxt.discFlag = 1'b0;
        end
        if (!resetn) begin
            state_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        state_r <= state_nxt;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign regRdData = state_r.rdData;
    assign linkPass10 = state_r.linkPass;
    assign crsOut = state_r.crs;
    assign heartbeatOut = state_r.heartbeat;
    assign txShutoff = state_r.jabbed;
    assign squelchSel = state_r.squelch;
    assign actSquelchSel = state_r.squelch;
    // trim acts on 10 Mb/s transmit only
    assign txTrimPct = speed10 ? trimPct(state_r.trim) : TRIM_ZERO;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_eof_set;
        eofErrEvt && speed10 && !softReset;
    endsequence

    sequence s_ctrl_read;
        rdCtrl && !eofErrEvt && !softReset;
    endsequence

    property p_eof_sticky;
        s_eof_set ##1 (!rdCtrl && !softReset) |=> state_r.eofErr;
    endproperty
    a_eof_sticky: assert property (p_eof_sticky)
        else $error("end-of-frame flag not held");

    property p_eof_read;
        s_eof_set ##1 s_ctrl_read
            |=> regRdData[BIT_EOF_ERR] && !state_r.eofErr;
    endproperty
    a_eof_read: assert property (p_eof_read)
        else $error("end-of-frame flag not reported then cleared");

    property p_disc_flag;
        cimLinkBroken && speed10 && !softReset |=> state_r.discFlag;
    endproperty
    a_disc_flag: assert property (p_disc_flag)
        else $error("disconnect flag missed");

    property p_link_force;
        speed10 && state_r.linkIntegDis |=> linkPass10;
    endproperty
    a_link_force: assert property (p_link_force)
        else $error("link pass not forced");

    property p_link_status;
        rdCtrl |=> regRdData[BIT_LINK_STATUS] == $past(linkPass10);
    endproperty
    a_link_status: assert property (p_link_status)
        else $error("link status bit wrong");

    property p_echo;
        !state_r.echoDis ##1 !state_r.echoDis
            |-> crsOut == $past(state_r.txEnSync);
    endproperty
    a_echo: assert property (p_echo)
        else $error("carrier sense does not echo transmit");

    property p_heartbeat;
        heartbeatReq && state_r.heartbeatDis && speed10 && halfDuplex
            |=> !heartbeatOut;
    endproperty
    a_heartbeat: assert property (p_heartbeat)
        else $error("heartbeat sent while disabled");

    property p_jabber;
        speed10 && state_r.txEnSync && !state_r.jabberDis
            && state_r.jabCnt == JABBER_LIMIT_CYC |=> txShutoff;
    endproperty
    a_jabber: assert property (p_jabber)
        else $error("transmitter not cut at jabber limit");

    property p_ctrl_reserved;
        rdCtrl |=> regRdData[9] == 1'b0 && regRdData[2:0] == 3'h0;
    endproperty
    a_ctrl_reserved: assert property (p_ctrl_reserved)
        else $error("reserved control bits not zero");

endmodule

// ### verification/phyec_mgr_model.sv
`timescale 1ns/1ps
module phyec_mgr_model (
    // clock
    input wire logic clk,
    // register port toward the device
    output logic [4:0] regAddr,
    output logic regWrEn,
    output logic regRdEn,
    output logic [15:0] regWrData,
    input wire logic [15:0] regRdData
);

    // idle port, strobes low
    initial begin
        regAddr = 5'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regWrData = 16'h0000;
    end

    // one write strobe; released lines flip so stale data never helps
    task wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask

    // one read strobe; data sampled a full cycle later to be safe
    task rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        regAddr = ~a;
        @(negedge clk);
        d = regRdData;
    endtask
endmodule

// ### verification/phyec_tb_top.sv
`timescale 1ns/1ps
module phyec_tb_top;
    import phyec_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic softReset = 1'b0;
    logic [1:0] speedSel = SPEED_100;
    logic halfDuplex = 1'b0;
    logic rxCollision = 1'b0;
    logic linkIntegrityOk = 1'b0;
    logic txEnPin = 1'b0;
    logic heartbeatReq = 1'b0;
    logic [4:0] evt = 5'h00;
    logic [4:0] regAddr;
    logic regWrEn, regRdEn;
    logic [15:0] regWrData, regRdData, rdv;
    logic linkPass10, crsOut, heartbeatOut, txShutoff;
    logic [1:0] squelchSel, actSquelchSel;
    logic signed [3:0] txTrimPct;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;

    // short jabber limit keeps the run brief
    phyec_top #(.JABBER_LIMIT_CYC(18'h0_0014)) i_dut (
        .clk(clk), .resetn(resetn), .softReset(softReset),
        .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regWrData(regWrData), .regRdData(regRdData),
        .speedSel(speedSel), .halfDuplex(halfDuplex),
        .rxErrPktEnd(evt[0]), .rxCollision(rxCollision),
        .falseCarrierEvt(evt[1]), .cimUnstableEnter(evt[2]),
        .cimLinkBroken(evt[3]), .eofErrEvt(evt[4]),
        .linkIntegrityOk(linkIntegrityOk), .txEnPin(txEnPin),
        .heartbeatReq(heartbeatReq), .linkPass10(linkPass10),
        .crsOut(crsOut), .heartbeatOut(heartbeatOut),
        .txShutoff(txShutoff), .squelchSel(squelchSel),
        .actSquelchSel(actSquelchSel), .txTrimPct(txTrimPct)
    );

    phyec_mgr_model i_mgr (
        .clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData)
    );

    // ----------------------------------------------------------------
    // clock, timeout and helpers
    // ----------------------------------------------------------------
    always #50 clk = ~clk;

    // cut a hang short well past the expected length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            complete_run();
        end
    end

    task complete_run();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    // event pulses held high for n back-to-back edges
    task pulse(input logic [4:0] m, input int n);
        @(negedge clk);
        evt = m;
        wt(n);
        evt = 5'h00;
    endtask

    task rc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
        i_mgr.rd(a, rdv);
        chk(rdv & m, e);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset();
        for (int a = 19; a <= 22; a++) begin
            rc(5'(a), 16'hFFFF, 16'h0000);
        end
    endtask

    // error and false carrier events at 10 Mb/s must not count
    task t_rx_err();
        speedSel = SPEED_10;
        pulse(5'h03, 2);
        speedSel = SPEED_100;
        pulse(5'h01, 3);
        rxCollision = 1'b1;
        pulse(5'h01, 2);
        rxCollision = 1'b0;
        rc(ADDR_RX_ERR_CNT, 16'hFFFF, 16'h0003);
        rc(ADDR_RX_ERR_CNT, 16'hFFFF, 16'h0000);
        rc(ADDR_FALSE_CARRIER_CNT, 16'hFFFF, 16'h0000);
    endtask

    // overflow past the top, then a write that must not clear it
    task t_false_carrier();
        speedSel = SPEED_1000;
        pulse(5'h02, 300);
        i_mgr.wr(ADDR_FALSE_CARRIER_CNT, 16'h0000);
        rc(ADDR_FALSE_CARRIER_CNT, 16'hFFFF, 16'h00FF);
        rc(ADDR_FALSE_CARRIER_CNT, 16'hFFFF, 16'h0000);
    endtask

    // event landing on the clearing read must survive it
    task t_disconnect();
        pulse(5'h04, 5);
        fork
            i_mgr.rd(ADDR_DISCONNECT_CNT, rdv);
            pulse(5'h04, 1);
        join
        chk(rdv, 16'h0005);
        rc(ADDR_DISCONNECT_CNT, 16'hFFFF, 16'h0001);
        i_mgr.wr(ADDR_TEN_BASE_T_CTRL, 16'h3000);
        pulse(5'h04, 2);
        @(negedge clk);
        softReset = 1'b1;
        @(negedge clk);
        softReset = 1'b0;
        rc(ADDR_DISCONNECT_CNT, 16'hFFFF, 16'h0000);
        // soft reset keeps controls, hardware reset clears everything
        rc(ADDR_TEN_BASE_T_CTRL, 16'hFC38, 16'h3000);
        pulse(5'h04, 2);
        resetn = 1'b0;
        wt(2);
        resetn = 1'b1;
        rc(ADDR_DISCONNECT_CNT, 16'hFFFF, 16'h0000);
        rc(ADDR_TEN_BASE_T_CTRL, 16'hFC38, 16'h0000);
    endtask

    task t_ctrl_bits();
        i_mgr.wr(ADDR_TEN_BASE_T_CTRL, 16'hFFFF);
        // flag events outside 10 Mb/s are ignored
        pulse(5'h18, 1);
        rc(ADDR_TEN_BASE_T_CTRL, 16'hFFBF, 16'hFC38);
        i_mgr.wr(ADDR_TEN_BASE_T_CTRL, 16'h0000);
    endtask

    task t_flags();
        speedSel = SPEED_10;
        // read on the edge right after both flags set
        fork
            pulse(5'h18, 1);
            begin
                @(negedge clk);
                i_mgr.rd(ADDR_TEN_BASE_T_CTRL, rdv);
            end
        join
        chk(rdv & 16'h0180, 16'h0180);
        rc(ADDR_TEN_BASE_T_CTRL, 16'h0180, 16'h0000);
        fork
            i_mgr.rd(ADDR_TEN_BASE_T_CTRL, rdv);
            pulse(5'h10, 1);
        join
        chk(rdv & 16'h0100, 16'h0000);
        rc(ADDR_TEN_BASE_T_CTRL, 16'h0100, 16'h0100);
    endtask

    task t_link();
        linkIntegrityOk = 1'b1;
        wt(3);
        chk(16'(linkPass10), 16'h0001);
        rc(ADDR_TEN_BASE_T_CTRL, 16'h0040, 16'h0040);
        linkIntegrityOk = 1'b0;
        wt(3);
        chk(16'(linkPass10), 16'h0000);
        rc(ADDR_TEN_BASE_T_CTRL, 16'h0040, 16'h0000);
        i_mgr.wr(ADDR_TEN_BASE_T_CTRL, 16'h8000);
        wt(3);
        chk(16'(linkPass10), 16'h0001);
        speedSel = SPEED_100;
        wt(3);
        chk(16'(linkPass10), 16'h0000);
        speedSel = SPEED_10;
    endtask

    // trim percentages per code, worked out independently
    function automatic logic [3:0] trim_exp(input int c);
        case (c)
            3, 2: return 4'h6;
            1: return 4'h4;
            0: return 4'h2;
            7: return 4'h0;
            6: return 4'hE;
            default: return 4'hC;
        endcase
    endfunction

    task t_squelch_trim();
        for (int i = 0; i < 3; i++) begin
            i_mgr.wr(ADDR_TEN_BASE_T_CTRL, 16'(i << POS_SQUELCH));
            wt(2);
            chk(16'(squelchSel), 16'(i));
            chk(16'(actSquelchSel), 16'(i));
        end
        for (int c = 0; c < 8; c++) begin
            i_mgr.wr(ADDR_TEN_BASE_T_CTRL, 16'(c << POS_TRIM));
            wt(2);
            chk({12'h000, txTrimPct}, {12'h000, trim_exp(c)});
        end
        speedSel = SPEED_100;
        wt(2);
        chk({12'h000, txTrimPct}, 16'h0000);
    endtask

    // echo control acts at 10 and 100, ignored at 1000
    task t_echo();
        for (int s = 0; s < 3; s++) begin
            speedSel = (s == 0) ? SPEED_10
                : ((s == 1) ? SPEED_100 : SPEED_1000);
            for (int e = 0; e < 2; e++) begin
                i_mgr.wr(ADDR_TEN_BASE_T_CTRL, 16'(e << BIT_ECHO_DIS));
                txEnPin = 1'b1;
                wt(5);
                chk(16'(crsOut), 16'(e == 0 || s == 2));
                txEnPin = 1'b0;
                wt(5);
                chk(16'(crsOut), 16'h0000);
            end
        end
    endtask

    task t_heartbeat();
        speedSel = SPEED_10;
        for (int d = 0; d < 2; d++) begin
            halfDuplex = d[0];
            for (int h = 0; h < 2; h++) begin
                i_mgr.wr(ADDR_TEN_BASE_T_CTRL, 16'(h << BIT_HEARTBEAT_DIS));
                heartbeatReq = 1'b1;
                wt(3);
                chk(16'(heartbeatOut), 16'(!(h && d)));
                heartbeatReq = 1'b0;
                wt(3);
            end
        end
        // disable has no effect outside 10 Mb/s
        speedSel = SPEED_100;
        i_mgr.wr(ADDR_TEN_BASE_T_CTRL, 16'h1000);
        heartbeatReq = 1'b1;
        wt(3);
        chk(16'(heartbeatOut), 16'h0001);
        heartbeatReq = 1'b0;
        speedSel = SPEED_10;
    endtask

    // long transmit request against the shortened limit
    task t_jabber();
        for (int j = 0; j < 2; j++) begin
            i_mgr.wr(ADDR_TEN_BASE_T_CTRL, 16'(j << BIT_JABBER_DIS));
            txEnPin = 1'b1;
            wt(30);
            chk(16'(txShutoff), 16'(j == 0));
            txEnPin = 1'b0;
            wt(6);
            chk(16'(txShutoff), 16'h0000);
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        wt(2);
        resetn = 1'b1;
        t_reset();
        t_rx_err();
        t_false_carrier();
        speedSel = SPEED_100;
        t_disconnect();
        t_ctrl_bits();
        t_flags();
        t_link();
        t_squelch_trim();
        t_echo();
        t_heartbeat();
        t_jabber();
        complete_run();
    end
endmodule
